// ===== logic/tpa_pkg.sv
package tpa_pkg;

  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int IDX_W  = ADDR_W - 2;

  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_CTRL     = 14'h19B7;
  localparam logic [IDX_W-1:0] IDX_ARB_HIGH = 14'h19BF;
  localparam logic [IDX_W-1:0] IDX_ARB_LOW  = 14'h19C3;
  localparam logic [IDX_W-1:0] IDX_PTR_STAT = 14'h19C7;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ARB_RST  = 8'h00;

  // Control bit positions
  localparam int BIT_NDF_ONE  = 0;
  localparam int BIT_NDF_CONT = 1;
  localparam int BIT_POS      = 2;
  localparam int BIT_NEG      = 3;
  localparam int BIT_GUARD    = 4;
  localparam int BIT_FORCE    = 5;

  // Pointer byte fields
  localparam int NDF_LSB = 4;
  localparam int SS_LSB  = 2;
  localparam int NDF_W   = 4;
  localparam int SS_W    = 2;
  localparam int PTR_W   = 10;

  // Pointer coding
  localparam logic [NDF_W-1:0] N_NORMAL  = 4'h6;
  localparam logic [NDF_W-1:0] N_ENABLED = 4'h9;
  localparam logic [PTR_W-1:0] I_MASK    = 10'h2AA;
  localparam logic [PTR_W-1:0] D_MASK    = 10'h155;
  localparam logic [PTR_W-1:0] PTR_MAX   = 10'h30E;
  localparam logic [PTR_W-1:0] PTR_ZERO  = 10'h000;
  localparam logic [PTR_W-1:0] PTR_ONE   = 10'h001;

  // Spacing guard
  localparam int GUARD_FRAMES = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RESP = 2'b10
  } tpa_wr_state_type;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_DATA = 2'b10
  } tpa_rd_state_type;

endpackage : tpa_pkg

// ===== logic/tpa_frame_guard.sv
`timescale 1ns/1ps
module tpa_frame_guard
  import tpa_pkg::*;
#(
  parameter int GAP = GUARD_FRAMES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Frame events
  input  wire logic frameStart,
  input  wire logic eventTaken,
  input  wire logic enable,
  // Result
  output logic      spacingOk
);

  logic [3:0] count_r;
  logic [3:0] count_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Frames since last pointer event, saturating
  always_comb begin
    count_nxt = count_r;
    if (frameStart && eventTaken) begin
      count_nxt = 4'h0;
    end else if (frameStart && (count_r < 4'(GAP))) begin
      count_nxt = count_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_r <= 4'(GAP);
    end else begin
      count_r <= count_nxt;
    end
  end

  assign spacingOk = !enable || (count_r >= 4'(GAP));

endmodule : tpa_frame_guard

// ===== logic/tpa_pointer_ctrl.sv
`timescale 1ns/1ps
// Function
// - Force load takes flag bits from 7:4
// - Force load takes size bits from 3:2
// - Forced pointer from high 1:0, low byte
// - Force applies next frame after bit5 rise
// - Bit 2 rise starts positive justification
// - Positive: stuff byte after H3
// - Positive: invert increment bits
// - Positive: pointer plus one afterwards
// - Bit 3 rise starts negative justification
// - Negative: payload byte in H3
// - Negative: invert decrement bits, minus one
// - Positive trigger bit clears itself
// - Negative trigger bit clears itself
// - Guard: no single flag or stuff event within three frames
// - Single and continuous flag events supported
// - Current pointer readable by software
// - Single flag: 1001 once, then 0110
// - Single flag trigger bit clears itself
module tpa_pointer_ctrl
  import tpa_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Outbound frame
  input  wire logic              frameStart,
  output logic [7:0]             txH1,
  output logic [7:0]             txH2,
  output logic                   posStuffFrame,
  output logic                   negStuffFrame
);

  tpa_wr_state_type  wrState_r, wrState_nxt;
  tpa_rd_state_type  rdState_r, rdState_nxt;
  logic              awGot_r, awGot_nxt, wGot_r, wGot_nxt;
  logic              awready_r, awready_nxt, wready_r, wready_nxt;
  logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt, wdata_r, wdata_nxt;
  logic [IDX_W-1:0]  wIdx_r, wIdx_nxt, rIdx;
  logic              wLane_r, wLane_nxt, wrFire, ctrlWr;
  logic [7:0]        ctrlView, wByte;
  logic              onePend_r, onePend_nxt, posPend_r, posPend_nxt;
  logic              negPend_r, negPend_nxt, forcePend_r, forcePend_nxt;
  logic              forceBit_r, forceBit_nxt, guardBit_r, guardBit_nxt;
  logic              contBit_r, contBit_nxt;
  logic [7:0]        arbHigh_r, arbHigh_nxt, arbLow_r, arbLow_nxt;
  logic [PTR_W-1:0]  curPtr_r, curPtr_nxt, arbPtr, word;
  logic [SS_W-1:0]   curSs_r, curSs_nxt, ssBits;
  logic [NDF_W-1:0]  nBits;
  logic [7:0]        h1_r, h1_nxt, h2_r, h2_nxt;
  logic              pos_r, pos_nxt, neg_r, neg_nxt;
  logic              takeForce, takeOne, takeCont, takePos, takeNeg;
  logic              ptrEvent, spacingOk;

  assign arbPtr   = {arbHigh_r[1:0], arbLow_r};
  assign ctrlView = {2'b00, forceBit_r, guardBit_r, negPend_r, posPend_r,
                     contBit_r, onePend_r};
  assign rIdx     = s_axi_araddr[ADDR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always_comb begin
    wrState_nxt = wrState_r;
    awGot_nxt   = awGot_r;
    wGot_nxt    = wGot_r;
    wIdx_nxt    = wIdx_r;
    wdata_nxt   = wdata_r;
    wLane_nxt   = wLane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    wrFire      = 1'b0;
    case (wrState_r)
      WS_IDLE: begin
        if (s_axi_awvalid && awready_r) begin
          awGot_nxt = 1'b1;
          wIdx_nxt  = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && wready_r) begin
          wGot_nxt  = 1'b1;
          wdata_nxt = s_axi_wdata;
          wLane_nxt = s_axi_wstrb[0];
        end
        if (awGot_nxt && wGot_nxt) begin
          wrFire      = 1'b1;
          awGot_nxt   = 1'b0;
          wGot_nxt    = 1'b0;
          bvalid_nxt  = 1'b1;
          wrState_nxt = WS_RESP;
          if (wIdx_nxt == IDX_CTRL || wIdx_nxt == IDX_ARB_HIGH ||
              wIdx_nxt == IDX_ARB_LOW || wIdx_nxt == IDX_PTR_STAT) begin
            bresp_nxt = RESP_OKAY;
          end else begin
            bresp_nxt = RESP_SLVERR;
          end
        end
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt  = 1'b0;
          wrState_nxt = WS_IDLE;
        end
      end
      default: wrState_nxt = WS_IDLE;
    endcase
    awready_nxt = (wrState_nxt == WS_IDLE) && !awGot_nxt;
    wready_nxt  = (wrState_nxt == WS_IDLE) && !wGot_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb begin
    rdState_nxt = rdState_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    rvalid_nxt  = rvalid_r;
    case (rdState_r)
      RS_IDLE: begin
        if (s_axi_arvalid && arready_r) begin
          rvalid_nxt  = 1'b1;
          rdState_nxt = RS_DATA;
          rresp_nxt   = RESP_OKAY;
          if (rIdx == IDX_CTRL) begin
            rdata_nxt = {24'h000000, ctrlView};
          end else if (rIdx == IDX_ARB_HIGH) begin
            rdata_nxt = {24'h000000, arbHigh_r};
          end else if (rIdx == IDX_ARB_LOW) begin
            rdata_nxt = {24'h000000, arbLow_r};
          end else if (rIdx == IDX_PTR_STAT) begin
            rdata_nxt = {22'h0, curPtr_r};
          end else begin
            rdata_nxt = 32'h00000000;
            rresp_nxt = RESP_SLVERR;
          end
        end
      end
      RS_DATA: begin
        if (s_axi_rready) begin
          rvalid_nxt  = 1'b0;
          rdState_nxt = RS_IDLE;
        end
      end
      default: rdState_nxt = RS_IDLE;
    endcase
    arready_nxt = (rdState_nxt == RS_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and pointer registers
  assign wByte  = wdata_nxt[7:0];
  assign ctrlWr = wrFire && wLane_nxt && (wIdx_nxt == IDX_CTRL);

  always_comb begin
    arbHigh_nxt  = arbHigh_r;
    arbLow_nxt   = arbLow_r;
    forceBit_nxt = forceBit_r;
    guardBit_nxt = guardBit_r;
    contBit_nxt  = contBit_r;
    if (wrFire && wLane_nxt && wIdx_nxt == IDX_ARB_HIGH) begin
      arbHigh_nxt = wByte;
    end else if (wrFire && wLane_nxt && wIdx_nxt == IDX_ARB_LOW) begin
      arbLow_nxt = wByte;
    end
    if (ctrlWr) begin
      forceBit_nxt = wByte[BIT_FORCE];
      guardBit_nxt = wByte[BIT_GUARD];
      contBit_nxt  = wByte[BIT_NDF_CONT];
    end
    // Set wins over the self-clear
    forcePend_nxt = (forcePend_r && !takeForce) ||
                    (ctrlWr && wByte[BIT_FORCE] && !forceBit_r);
    onePend_nxt = (onePend_r && !takeOne) ||
                  (ctrlWr && wByte[BIT_NDF_ONE]);
    posPend_nxt = (posPend_r && !takePos) ||
                  (ctrlWr && wByte[BIT_POS]);
    negPend_nxt = (negPend_r && !takeNeg) ||
                  (ctrlWr && wByte[BIT_NEG]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-frame pointer generation
  always_comb begin
    curPtr_nxt = curPtr_r;
    curSs_nxt  = curSs_r;
    h1_nxt     = h1_r;
    h2_nxt     = h2_r;
    pos_nxt    = pos_r;
    neg_nxt    = neg_r;
    nBits      = N_NORMAL;
    ssBits     = curSs_r;
    word       = curPtr_r;
    takeForce  = 1'b0;
    takeOne    = 1'b0;
    takeCont   = 1'b0;
    takePos    = 1'b0;
    takeNeg    = 1'b0;
    if (frameStart) begin
      pos_nxt = 1'b0;
      neg_nxt = 1'b0;
      if (forcePend_r) begin
        takeForce  = 1'b1;
        nBits      = arbHigh_r[NDF_LSB+:NDF_W];
        ssBits     = arbHigh_r[SS_LSB+:SS_W];
        word       = arbPtr;
        curPtr_nxt = arbPtr;
        curSs_nxt  = arbHigh_r[SS_LSB+:SS_W];
      end else if (onePend_r && spacingOk) begin
        takeOne    = 1'b1;
        nBits      = N_ENABLED;
        word       = arbPtr;
        curPtr_nxt = arbPtr;
      end else if (contBit_r) begin
        takeCont   = 1'b1;
        nBits      = N_ENABLED;
        word       = arbPtr;
        curPtr_nxt = arbPtr;
      end else if (posPend_r && spacingOk) begin
        takePos    = 1'b1;
        word       = curPtr_r ^ I_MASK;
        pos_nxt    = 1'b1;
        curPtr_nxt = (curPtr_r == PTR_MAX) ? PTR_ZERO :
                     curPtr_r + PTR_ONE;
      end else if (negPend_r && spacingOk) begin
        takeNeg    = 1'b1;
        word       = curPtr_r ^ D_MASK;
        neg_nxt    = 1'b1;
        curPtr_nxt = (curPtr_r == PTR_ZERO) ? PTR_MAX :
                     curPtr_r - PTR_ONE;
      end
      h1_nxt = {nBits, ssBits, word[PTR_W-1:8]};
      h2_nxt = word[7:0];
    end
  end

  assign ptrEvent = takeForce || takeOne || takeCont || takePos || takeNeg;

  tpa_frame_guard #(
    .GAP        (GUARD_FRAMES)
  ) u_guard (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .frameStart (frameStart),
    .eventTaken (ptrEvent),
    .enable     (guardBit_r),
    .spacingOk  (spacingOk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wrState_r <= WS_IDLE;
      rdState_r <= RS_IDLE;
      {awGot_r, wGot_r, awready_r, wready_r} <= 4'h0;
      {bvalid_r, arready_r, rvalid_r, wLane_r} <= 4'h0;
      bresp_r     <= RESP_OKAY;
      rresp_r     <= RESP_OKAY;
      rdata_r     <= 32'h00000000;
      wdata_r     <= 32'h00000000;
      wIdx_r      <= IDX_CTRL;
      {onePend_r, posPend_r, negPend_r, forcePend_r} <= 4'h0;
      forceBit_r  <= CTRL_RST[BIT_FORCE];
      guardBit_r  <= CTRL_RST[BIT_GUARD];
      contBit_r   <= CTRL_RST[BIT_NDF_CONT];
      arbHigh_r   <= ARB_RST;
      arbLow_r    <= ARB_RST;
      curPtr_r    <= PTR_ZERO;
      curSs_r     <= ARB_RST[SS_LSB+:SS_W];
      h1_r        <= {N_NORMAL, ARB_RST[SS_LSB+:SS_W], 2'h0};
      h2_r        <= ARB_RST;
      pos_r       <= 1'b0;
      neg_r       <= 1'b0;
    end else begin
      wrState_r   <= wrState_nxt;
      rdState_r   <= rdState_nxt;
      {awGot_r, wGot_r, awready_r, wready_r} <=
        {awGot_nxt, wGot_nxt, awready_nxt, wready_nxt};
      {bvalid_r, arready_r, rvalid_r, wLane_r} <=
        {bvalid_nxt, arready_nxt, rvalid_nxt, wLane_nxt};
      bresp_r     <= bresp_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
      wdata_r     <= wdata_nxt;
      wIdx_r      <= wIdx_nxt;
      {onePend_r, posPend_r, negPend_r, forcePend_r} <=
        {onePend_nxt, posPend_nxt, negPend_nxt, forcePend_nxt};
      forceBit_r  <= forceBit_nxt;
      guardBit_r  <= guardBit_nxt;
      contBit_r   <= contBit_nxt;
      arbHigh_r   <= arbHigh_nxt;
      arbLow_r    <= arbLow_nxt;
      curPtr_r    <= curPtr_nxt;
      curSs_r     <= curSs_nxt;
      h1_r        <= h1_nxt;
      h2_r        <= h2_nxt;
      pos_r       <= pos_nxt;
      neg_r       <= neg_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign txH1          = h1_r;
  assign txH2          = h2_r;
  assign posStuffFrame = pos_r;
  assign negStuffFrame = neg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  force_ndf_a: assert property (frameStart && forcePend_r |=>
    txH1[7:4] == $past(arbHigh_r[7:4])) else $error("forced flag wrong");
  force_ss_a: assert property (frameStart && forcePend_r |=>
    txH1[3:2] == $past(arbHigh_r[3:2])) else $error("forced size wrong");
  force_ptr_a: assert property (takeForce |=>
    {txH1[1:0], txH2} == $past(arbPtr) && curPtr_r == $past(arbPtr))
    else $error("forced pointer wrong");
  force_edge_a: assert property (
    ctrlWr && wByte[BIT_FORCE] && !forceBit_r |=> forcePend_r)
    else $error("force edge lost");
  pos_stuff_a: assert property (takePos |=> posStuffFrame &&
    {txH1[1:0], txH2} == ($past(curPtr_r) ^ I_MASK))
    else $error("positive stuff frame wrong");
  pos_step_a: assert property (takePos && curPtr_r != PTR_MAX |=>
    curPtr_r == $past(curPtr_r) + PTR_ONE) else $error("no increment");
  neg_stuff_a: assert property (takeNeg |=> negStuffFrame &&
    {txH1[1:0], txH2} == ($past(curPtr_r) ^ D_MASK))
    else $error("negative stuff frame wrong");
  pos_clear_a: assert property (takePos && !ctrlWr |=> !posPend_r)
    else $error("positive trigger not cleared");
  neg_clear_a: assert property (takeNeg && !ctrlWr |=> !negPend_r)
    else $error("negative trigger not cleared");
  guard_hold_a: assert property (frameStart && !spacingOk &&
    !forcePend_r && !contBit_r |=> txH1[7:4] == N_NORMAL &&
    !posStuffFrame && !negStuffFrame) else $error("guard violated");
  one_ndf_a: assert property (frameStart && !forcePend_r &&
    !contBit_r && !(onePend_r && spacingOk) |=> txH1[7:4] == N_NORMAL)
    else $error("flag did not return to normal");

endmodule : tpa_pointer_ctrl

// ===== verification/tpa_frame_source.sv
`timescale 1ns/1ps
module tpa_frame_source #(
  parameter int FRAME_LEN = 16
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Run control
  input  wire logic frameGo,
  // Frame marks
  output logic      frameStart,
  output logic      frameTick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       start_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Frame counter, clears to zero while not running
  always_comb begin
    cnt_nxt   = 8'h00;
    start_nxt = 1'b0;
    if (frameGo) begin
      start_nxt = (cnt_r == 8'(FRAME_LEN - 1));
      cnt_nxt   = start_nxt ? 8'h00 : cnt_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r      <= 8'h00;
      frameStart <= 1'b0;
      frameTick  <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      frameStart <= start_nxt;
      frameTick  <= frameStart;
    end
  end
endmodule : tpa_frame_source

// ===== verification/tx_pointer_adjust_control_bench.sv
`timescale 1ns/1ps
module tx_pointer_adjust_control_bench
  import tpa_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              reset   = 1'b1;
  logic [ADDR_W-1:0] awAddr  = '0;
  logic              awValid = 1'b0;
  logic [31:0]       wData   = '0;
  logic [3:0]        wStrb   = '0;
  logic              wValid  = 1'b0;
  logic              bReady  = 1'b0;
  logic [ADDR_W-1:0] arAddr  = '0;
  logic              arValid = 1'b0;
  logic              rReady  = 1'b0;
  logic              frameGo = 1'b0;
  logic              awReady, wReady, bValid, arReady, rValid;
  logic              frameStart, frameTick, posStuff, negStuff;
  logic [1:0]        bResp, rResp;
  logic [31:0]       rData;
  logic [7:0]        txH1, txH2;
  logic [1:0]        bQ[$];
  logic [33:0]       rQ[$];
  logic [17:0]       fQ[$];
  logic [17:0]       fE;
  logic [PTR_W-1:0]  ptr = PTR_ZERO;
  logic [PTR_W-1:0]  p;
  logic [1:0]        ss = 2'h0;
  logic [7:0]        hi;
  int                miscompares = 0;
  int                n_compared  = 0;
  int                seed        = 66987;

  always #25 ref_clk = ~ref_clk;

  tpa_pointer_ctrl tpa_pointer_ctrl_i (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .frameStart(frameStart),
    .txH1(txH1), .txH2(txH2), .posStuffFrame(posStuff),
    .negStuffFrame(negStuff));

  tpa_frame_source tpa_frame_source_i (
    .ref_clk(ref_clk), .reset(reset), .frameGo(frameGo),
    .frameStart(frameStart), .frameTick(frameTick));

  ////////////////////////////////////////////////////////////////////////////
  // Checking
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    if (bValid && bReady) chk(34'(bResp), 34'(bQ.pop_front()));
    if (rValid && rReady) chk({rResp, rData}, rQ.pop_front());
    if (frameTick) begin
      fE = fQ.pop_front();
      chk(34'(txH1), 34'(fE[15:8]));
      chk(34'(txH2), 34'(fE[7:0]));
      chk(34'({posStuff, negStuff}), 34'(fE[17:16]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus master
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic aDone, dDone;
    aDone = 1'b0;
    dDone = 1'b0;
    bQ.push_back(r);
    @(posedge ref_clk);
    awAddr  <= {i, 2'b00};
    wData   <= {24'h000000, d};
    wStrb   <= s;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (!(aDone && dDone)) begin
      @(posedge ref_clk);
      if (awValid && awReady) begin
        aDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady) begin
        dDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!bValid);
    bReady <= 1'b0;
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] d,
                    input logic [1:0] r);
    rQ.push_back({r, d});
    @(posedge ref_clk);
    arAddr  <= {i, 2'b00};
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do @(posedge ref_clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge ref_clk); while (!rValid);
    rReady <= 1'b0;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Frames
  task automatic expF(input logic [3:0] n, input logic [PTR_W-1:0] w,
                      input logic ps, input logic ng);
    fQ.push_back({ps, ng, n, ss, w});
  endtask : expF

  task automatic frames(input int n);
    int k;
    k = 0;
    @(posedge ref_clk);
    frameGo <= 1'b1;
    while (k < n) begin
      @(posedge ref_clk);
      if (frameTick) k++;
    end
    frameGo <= 1'b0;
  endtask : frames

  task automatic quiet(input int n);
    repeat (n) expF(N_NORMAL, ptr, 1'b0, 1'b0);
    frames(n);
  endtask : quiet

  task automatic stuff(input logic [7:0] c, input logic up);
    wr(IDX_CTRL, c, 4'h1, RESP_OKAY);
    rd(IDX_CTRL, 32'(c), RESP_OKAY);
    expF(N_NORMAL, ptr ^ (up ? I_MASK : D_MASK), up, !up);
    frames(1);
    if (up) ptr = (ptr == PTR_MAX) ? PTR_ZERO : ptr + PTR_ONE;
    else ptr = (ptr == PTR_ZERO) ? PTR_MAX : ptr - PTR_ONE;
    rd(IDX_CTRL, 32'(c & 8'h10), RESP_OKAY);
    rd(IDX_PTR_STAT, 32'(ptr), RESP_OKAY);
  endtask : stuff

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(IDX_CTRL, 32'(CTRL_RST), RESP_OKAY);
    rd(IDX_ARB_HIGH, 32'(ARB_RST), RESP_OKAY);
    rd(IDX_ARB_LOW, 32'(ARB_RST), RESP_OKAY);
    rd(IDX_PTR_STAT, 32'h0, RESP_OKAY);
    rd(14'h0001, 32'h0, RESP_SLVERR);
    wr(14'h0001, 8'hFF, 4'h1, RESP_SLVERR);
    quiet(1);
    $display("test reset done");
    p  = 10'($unsigned($random(seed)) % 783);
    hi = {4'($random(seed)), 2'($random(seed)), p[9:8]};
    wr(IDX_ARB_HIGH, hi, 4'h1, RESP_OKAY);
    wr(IDX_ARB_LOW, p[7:0], 4'h1, RESP_OKAY);
    wr(IDX_ARB_LOW, ~p[7:0], 4'h0, RESP_OKAY);
    rd(IDX_ARB_HIGH, 32'(hi), RESP_OKAY);
    rd(IDX_ARB_LOW, 32'(p[7:0]), RESP_OKAY);
    wr(IDX_CTRL, 8'h20, 4'h1, RESP_OKAY);
    ss  = hi[3:2];
    ptr = p;
    expF(hi[7:4], p, 1'b0, 1'b0);
    frames(1);
    quiet(1);
    rd(IDX_PTR_STAT, 32'(ptr), RESP_OKAY);
    $display("test force done");
    stuff(8'h04, 1'b1);
    quiet(1);
    stuff(8'h08, 1'b0);
    quiet(1);
    $display("test stuff done");
    wr(IDX_ARB_HIGH, {4'h0, ss, PTR_MAX[9:8]}, 4'h1, RESP_OKAY);
    wr(IDX_ARB_LOW, PTR_MAX[7:0], 4'h1, RESP_OKAY);
    wr(IDX_CTRL, 8'h01, 4'h1, RESP_OKAY);
    rd(IDX_CTRL, 32'h01, RESP_OKAY);
    ptr = PTR_MAX;
    expF(N_ENABLED, ptr, 1'b0, 1'b0);
    frames(1);
    rd(IDX_CTRL, 32'h00, RESP_OKAY);
    quiet(1);
    wr(IDX_CTRL, 8'h02, 4'h1, RESP_OKAY);
    repeat (2) expF(N_ENABLED, ptr, 1'b0, 1'b0);
    frames(2);
    wr(IDX_CTRL, 8'h00, 4'h1, RESP_OKAY);
    quiet(4);
    $display("test flag done");
    stuff(8'h14, 1'b1);
    wr(IDX_CTRL, 8'h18, 4'h1, RESP_OKAY);
    quiet(3);
    rd(IDX_CTRL, 32'h18, RESP_OKAY);
    expF(N_NORMAL, ptr ^ D_MASK, 1'b0, 1'b1);
    frames(1);
    ptr = (ptr == PTR_ZERO) ? PTR_MAX : ptr - PTR_ONE;
    quiet(1);
    $display("test guard done");
    end_sim();
  end

  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule : tx_pointer_adjust_control_bench
